/* hw/osw_pkg.sv */
// Package for the per-axis origin search and wiring check block.
// Assumes a 125 MHz system clock; all register offsets are byte addresses on Avalon-MM.
package osw_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int PULSE_HALF_US = 5;
    localparam int PULSE_HALF_CYCLES = CLK_HZ / 1000000 * PULSE_HALF_US;
    localparam int HI_DIV = 8;
    localparam int LO_DIV = 64;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CFG = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam logic [3:0] OFF_CORR = 4'hC;

    // Control bits.
    localparam int CTRL_SEARCH = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_ABORT = 2;

    // Configuration field positions.
    localparam int CFG_ZDIR = 0;
    localparam int CFG_START_OPP = 1;
    localparam int CFG_DECEL_LIMIT = 2;
    localparam int CFG_STOP_RAMP = 3;
    localparam int CFG_PROX_NC = 4;
    localparam int CFG_WCHK_EN = 5;
    localparam int CFG_ONE_DIR = 6;
    localparam int CFG_ABS_EN = 7;
    localparam int CFG_WTIME_LSB = 8;
    localparam int CFG_WPULSE_LSB = 16;

    localparam logic [6:0] WTIME_RST = 7'h0A;
    localparam logic [9:0] WPULSE_RST = 10'h032;
    localparam logic [6:0] WTIME_MAX = 7'h63;
    localparam logic [9:0] WPULSE_MAX = 10'h3E7;

    typedef struct packed {
        logic [9:0] wpulse;
        logic [6:0] wtime;
        logic abs_en;
        logic one_dir;
        logic wchk_en;
        logic prox_nc;
        logic stop_ramp;
        logic decel_limit;
        logic start_opp;
        logic zdir_neg;
    } osw_cfg_t;

    typedef struct packed {
        logic prox;
        logic lim_pos;
        logic lim_neg;
        logic phase_z;
        logic fb_pulse;
    } osw_in_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_HIGH = 7'h02,
        ST_LOW = 7'h04,
        ST_RAMP = 7'h08,
        ST_DONE = 7'h10,
        ST_WCHK = 7'h20,
        ST_WWAIT = 7'h40
    } osw_state_t;

endpackage : osw_pkg

/* hw/osw_pulse_gen.sv */
// Step pulse generator: one pulse per request, fixed width.
// Assumes a single clock; request is ignored while a pulse is out.
`timescale 1ns/1ps

module osw_pulse_gen (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic req_i,
    output logic pulse_o,
    output logic busy_o
);

    logic [9:0] cnt;
    logic [1:0] phase;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt <= 10'h000;
            phase <= 2'h0;
            pulse_o <= 1'b0;
        end
        else if (phase == 2'h0)
        begin
            if (req_i)
            begin
                phase <= 2'h1;
                pulse_o <= 1'b1;
                cnt <= 10'(osw_pkg::PULSE_HALF_CYCLES - 1);
            end
        end
        else if (cnt != 10'h000)
        begin
            cnt <= cnt - 10'h001;
        end
        else if (phase == 2'h1)
        begin
            phase <= 2'h2;
            pulse_o <= 1'b0;
            cnt <= 10'(osw_pkg::PULSE_HALF_CYCLES - 1);
        end
        else
        begin
            phase <= 2'h0;
        end
    end

    assign busy_o = (phase != 2'h0);

endmodule : osw_pulse_gen

/* hw/osw_axis.sv */
// Per-axis origin search and power-on wiring check with an Avalon-MM register slave.
// Assumes inputs synchronous to clock_i; the servo driver returns one feedback pulse per step.
`timescale 1ns/1ps

module osw_axis (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire osw_pkg::osw_in_t axis_in_i,
    input wire logic [31:0] abs_pos_i,
    output logic step_o,
    output logic dir_neg_o,
    output logic servo_on_o,
    output logic [31:0] abs_corr_pos_o
);

    // ==========================================================
    // Register slave
    // ==========================================================
    osw_pkg::osw_cfg_t cfg;
    logic [31:0] corr;
    logic lock_req;
    logic search_pulse;
    logic abort_pulse;
    logic ack;
    logic wchk_done;
    logic wchk_err;
    logic limit_err;
    logic origin_found;
    logic [9:0] fb_count;
    osw_pkg::osw_state_t state;
    logic [3:0] flags;

    wire logic access = (avs_read_i | avs_write_i) & ~ack;
    // A write lands only at the edge where waitrequest is seen low, never while the master still waits.
    wire logic wr = avs_write_i & ack;

    // One wait cycle, then a one-cycle acknowledge: waitrequest is low in the second cycle.
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= access;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            avs_waitrequest_o <= ~access;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg <= '0;
            cfg.wtime <= osw_pkg::WTIME_RST;
            cfg.wpulse <= osw_pkg::WPULSE_RST;
            cfg.wchk_en <= 1'b1;
            corr <= 32'h0000_0000;
            lock_req <= 1'b0;
            search_pulse <= 1'b0;
            abort_pulse <= 1'b0;
        end
        else
        begin
            search_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            if (wr && avs_address_i == osw_pkg::OFF_CTRL)
            begin
                search_pulse <= avs_writedata_i[osw_pkg::CTRL_SEARCH];
                lock_req <= avs_writedata_i[osw_pkg::CTRL_LOCK];
                abort_pulse <= avs_writedata_i[osw_pkg::CTRL_ABORT];
            end
            if (wr && avs_address_i == osw_pkg::OFF_CFG)
            begin
                // Bit 15 is a reserved hole between the time and pulse fields.
                cfg <= {avs_writedata_i[25:16], avs_writedata_i[14:0]};
                // Out-of-range settings saturate at the documented maxima.
                if (avs_writedata_i[14:8] > osw_pkg::WTIME_MAX)
                begin
                    cfg.wtime <= osw_pkg::WTIME_MAX;
                end
                if (avs_writedata_i[25:16] > osw_pkg::WPULSE_MAX)
                begin
                    cfg.wpulse <= osw_pkg::WPULSE_MAX;
                end
            end
            if (wr && avs_address_i == osw_pkg::OFF_CORR)
            begin
                corr <= avs_writedata_i;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i && access)
        begin
            unique case (avs_address_i)
                osw_pkg::OFF_CTRL: avs_readdata_o <= {30'h0, lock_req, 1'b0};
                osw_pkg::OFF_CFG: avs_readdata_o <= {6'h00, cfg.wpulse, 1'b0, cfg[14:0]};
                osw_pkg::OFF_STAT: avs_readdata_o <= {flags, 11'h000, fb_count, state};
                osw_pkg::OFF_CORR: avs_readdata_o <= corr;
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Status flags sit in bits 31..28 of the status word.
    assign flags = {wchk_err, wchk_done, limit_err, origin_found};

    // ==========================================================
    // Inputs and absolute correction
    // ==========================================================
    logic prox_act;
    logic lim_fwd;
    logic decel_act;
    assign prox_act = axis_in_i.prox ^ cfg.prox_nc;
    assign lim_fwd = dir_neg_o ? axis_in_i.lim_neg : axis_in_i.lim_pos;
    assign decel_act = cfg.decel_limit ? lim_fwd : prox_act;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            abs_corr_pos_o <= 32'h0000_0000;
        end
        else
        begin
            abs_corr_pos_o <= cfg.abs_en ? 32'(abs_pos_i + corr) : abs_pos_i;
        end
    end

    // ==========================================================
    // Step rate and pulse generator
    // ==========================================================
    logic [7:0] rate_cnt;
    logic [7:0] ramp_div;
    logic step_req;
    logic gen_pulse;
    logic gen_busy;
    logic moving;
    logic [9:0] sent;

    assign moving = (state == osw_pkg::ST_HIGH) || (state == osw_pkg::ST_LOW)
        || (state == osw_pkg::ST_RAMP) || (state == osw_pkg::ST_WCHK);
    // Without the last term the check would start one pulse too many as the last one ends.
    assign step_req = moving && rate_cnt == 8'h00 && !gen_busy
        && !(state == osw_pkg::ST_WCHK && sent == cfg.wpulse);

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rate_cnt <= 8'h00;
        end
        else if (!moving)
        begin
            rate_cnt <= 8'h00;
        end
        else if (step_req)
        begin
            unique case (state)
                osw_pkg::ST_HIGH: rate_cnt <= 8'(osw_pkg::HI_DIV);
                osw_pkg::ST_RAMP: rate_cnt <= ramp_div;
                default: rate_cnt <= 8'(osw_pkg::LO_DIV);
            endcase
        end
        else if (rate_cnt != 8'h00)
        begin
            rate_cnt <= rate_cnt - 8'h01;
        end
    end

    osw_pulse_gen u_gen (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .req_i(step_req),
        .pulse_o(gen_pulse),
        .busy_o(gen_busy)
    );

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            step_o <= 1'b0;
        end
        else
        begin
            step_o <= gen_pulse;
        end
    end

    // ==========================================================
    // Wiring check timer and feedback count
    // ==========================================================
    logic [20:0] tick_cnt;
    logic tick;
    logic [6:0] ticks;
    logic checked;

    assign tick = tick_cnt == 21'h000000;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt <= 21'h000000;
        end
        else if (state != osw_pkg::ST_WWAIT || tick)
        begin
            tick_cnt <= 21'(osw_pkg::TICK_CYCLES - 1);
        end
        else
        begin
            tick_cnt <= tick_cnt - 21'h000001;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ticks <= 7'h00;
        end
        else if (state != osw_pkg::ST_WWAIT)
        begin
            ticks <= 7'h00;
        end
        else if (tick && state == osw_pkg::ST_WWAIT && tick_cnt == 21'h000000)
        begin
            ticks <= ticks + 7'h01;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            fb_count <= 10'h000;
        end
        else if (state == osw_pkg::ST_IDLE && lock_req && !checked)
        begin
            fb_count <= 10'h000;
        end
        else if (axis_in_i.fb_pulse && fb_count != 10'h3FF)
        begin
            fb_count <= fb_count + 10'h001;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sent <= 10'h000;
        end
        else if (state == osw_pkg::ST_IDLE)
        begin
            sent <= 10'h000;
        end
        else if (step_req)
        begin
            sent <= sent + 10'h001;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    logic lim_any;
    assign lim_any = axis_in_i.lim_pos | axis_in_i.lim_neg;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state <= osw_pkg::ST_IDLE;
            dir_neg_o <= 1'b0;
            checked <= 1'b0;
            wchk_done <= 1'b0;
            wchk_err <= 1'b0;
            limit_err <= 1'b0;
            origin_found <= 1'b0;
            ramp_div <= 8'h00;
        end
        else if (abort_pulse)
        begin
            state <= osw_pkg::ST_IDLE;
        end
        else
        begin
            unique case (state)
                osw_pkg::ST_IDLE:
                begin
                    if (lock_req && !checked && cfg.wchk_en)
                    begin
                        checked <= 1'b1;
                        dir_neg_o <= 1'b0;
                        state <= osw_pkg::ST_WCHK;
                    end
                    else if (lock_req && !checked)
                    begin
                        checked <= 1'b1;
                    end
                    else if (search_pulse && servo_on_o)
                    begin
                        origin_found <= 1'b0;
                        limit_err <= 1'b0;
                        dir_neg_o <= cfg.zdir_neg ^ cfg.start_opp;
                        state <= osw_pkg::ST_HIGH;
                    end
                end
                osw_pkg::ST_WCHK:
                begin
                    if (sent == cfg.wpulse && !gen_busy)
                    begin
                        state <= osw_pkg::ST_WWAIT;
                    end
                end
                osw_pkg::ST_WWAIT:
                begin
                    if (fb_count == cfg.wpulse)
                    begin
                        wchk_done <= 1'b1;
                        state <= osw_pkg::ST_IDLE;
                    end
                    else if (ticks >= cfg.wtime)
                    begin
                        wchk_done <= 1'b1;
                        wchk_err <= 1'b1;
                        state <= osw_pkg::ST_IDLE;
                    end
                end
                osw_pkg::ST_HIGH:
                begin
                    if (decel_act)
                    begin
                        dir_neg_o <= cfg.zdir_neg;
                        state <= osw_pkg::ST_LOW;
                    end
                    else if (lim_fwd && !cfg.one_dir)
                    begin
                        dir_neg_o <= ~dir_neg_o;
                    end
                    else if (lim_fwd && cfg.stop_ramp)
                    begin
                        limit_err <= 1'b1;
                        ramp_div <= 8'(osw_pkg::HI_DIV);
                        state <= osw_pkg::ST_RAMP;
                    end
                    else if (lim_fwd)
                    begin
                        limit_err <= 1'b1;
                        state <= osw_pkg::ST_IDLE;
                    end
                end
                osw_pkg::ST_LOW:
                begin
                    if (axis_in_i.phase_z)
                    begin
                        origin_found <= 1'b1;
                        state <= osw_pkg::ST_DONE;
                    end
                    else if (lim_any)
                    begin
                        limit_err <= 1'b1;
                        state <= cfg.stop_ramp ? osw_pkg::ST_RAMP : osw_pkg::ST_IDLE;
                        ramp_div <= 8'(osw_pkg::LO_DIV);
                    end
                end
                osw_pkg::ST_RAMP:
                begin
                    if (step_req)
                    begin
                        ramp_div <= ramp_div + 8'h10;
                        if (ramp_div >= 8'hE0)
                        begin
                            state <= osw_pkg::ST_IDLE;
                        end
                    end
                end
                osw_pkg::ST_DONE:
                begin
                    state <= osw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            servo_on_o <= 1'b0;
        end
        else
        begin
            servo_on_o <= lock_req && !wchk_err;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_wchk_first: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_IDLE && lock_req && !checked && cfg.wchk_en && !abort_pulse
        |=> state == osw_pkg::ST_WCHK)
        else $error("wiring check did not start at first lock");
    a_err_blocks_servo: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wchk_err |=> !servo_on_o)
        else $error("servo on despite wiring error");
    a_prox_polarity: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_HIGH && !cfg.decel_limit && (axis_in_i.prox ^ cfg.prox_nc) && !abort_pulse
        |=> state == osw_pkg::ST_LOW)
        else $error("proximity did not start low speed");
    a_start_dir: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $rose(state == osw_pkg::ST_HIGH) |-> dir_neg_o == (cfg.zdir_neg ^ cfg.start_opp))
        else $error("wrong start direction");
    a_low_dir: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_LOW |-> dir_neg_o == cfg.zdir_neg)
        else $error("phase Z searched in wrong direction");
    a_abrupt_stop: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_LOW && !axis_in_i.phase_z && lim_any && !cfg.stop_ramp && !abort_pulse
        |=> state == osw_pkg::ST_IDLE ##1 rate_cnt == 8'h00)
        else $error("immediate stop not abrupt");
    a_one_dir_err: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_HIGH && cfg.one_dir && lim_fwd && !decel_act && !abort_pulse |=> limit_err)
        else $error("early limit not flagged");
    a_reverse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_HIGH && !cfg.one_dir && lim_fwd && !decel_act && !abort_pulse
        |=> dir_neg_o != $past(dir_neg_o))
        else $error("reverse mode did not turn back");
    a_timeout_err: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state == osw_pkg::ST_WWAIT && fb_count != cfg.wpulse && ticks >= cfg.wtime && !abort_pulse
        |=> wchk_err)
        else $error("timeout did not flag mismatch");

    c_check_ok: cover property (@(posedge clock_i) $fell(state == osw_pkg::ST_WWAIT) && !wchk_err);
    c_check_err: cover property (@(posedge clock_i) $rose(wchk_err));
    c_origin: cover property (@(posedge clock_i) $rose(origin_found));
    c_ramp: cover property (@(posedge clock_i) state == osw_pkg::ST_RAMP);

endmodule : osw_axis

/* verification/osw_servo_model.sv */
// Servo driver stand-in: one feedback pulse per rising step edge.
// Assumes step_i is synchronous to clock_i.
`timescale 1ns/1ps

module osw_servo_model #(
    parameter int LAG = 3
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic step_i,
    input wire logic [3:0] sense_i,
    output osw_pkg::osw_in_t axis_o
);
    logic step_q;
    logic [7:0] fb_pipe;

    // ====
    // Feedback echo
    // The lag models the encoder path, so feedback trails the steps.
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            step_q <= 1'b0;
            fb_pipe <= 8'h00;
        end
        else
        begin
            step_q <= step_i;
            fb_pipe <= {fb_pipe[6:0], step_i & ~step_q};
        end
    end

    assign axis_o = {sense_i, fb_pipe[LAG]};
endmodule : osw_servo_model

/* verification/tb_osw_axis.sv */
// Bench for the axis block: registers, wiring check, search.
// Assumes the servo model file and the design package.
`timescale 1ns/1ps

module tb_osw_axis;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    osw_pkg::osw_in_t axis_in_i;
    logic [31:0] abs_pos_i = 32'h00000100;
    logic step_o;
    logic dir_neg_o;
    logic servo_on_o;
    logic [31:0] abs_corr_pos_o;
    logic [3:0] sense = 4'h0;
    logic [31:0] q;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #4 clock_i = ~clock_i;

    osw_axis DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .axis_in_i(axis_in_i), .abs_pos_i(abs_pos_i), .step_o(step_o),
        .dir_neg_o(dir_neg_o), .servo_on_o(servo_on_o), .abs_corr_pos_o(abs_corr_pos_o));

    osw_servo_model #(.LAG(3)) servo (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .step_i(step_o), .sense_i(sense), .axis_o(axis_in_i));

    // ====
    // Shared tasks
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    // The request stays up until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clock_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus

    task automatic wst(input logic [6:0] st);
        int n = 0;
        do
        begin
            bus(1'b0, osw_pkg::OFF_STAT, 32'h0);
            n++;
        end
        while (q[6:0] !== st && n < 2000);
        chk({25'h0, q[6:0]}, {25'h0, st});
    endtask : wst

    // ====
    // Scenarios
    task automatic t_reset();
        bus(1'b0, osw_pkg::OFF_CFG, 32'h0);
        chk(q, 32'h00320A20);
        bus(1'b0, osw_pkg::OFF_STAT, 32'h0);
        chk(q, 32'h00000001);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h00000000);
    endtask : t_reset

    task automatic t_sat();
        bus(1'b1, osw_pkg::OFF_CFG, 32'h03FF7F20);
        bus(1'b0, osw_pkg::OFF_CFG, 32'h0);
        chk(q, 32'h03E76320);
    endtask : t_sat

    task automatic t_wchk();
        bus(1'b1, osw_pkg::OFF_CFG, 32'h00030A20);
        bus(1'b1, osw_pkg::OFF_CTRL, 32'h00000002);
        chk({31'h0, dir_neg_o}, 32'h0);
        wst(osw_pkg::ST_WCHK);
        wst(osw_pkg::ST_IDLE);
        chk({31'h0, servo_on_o}, 32'h1);
        bus(1'b0, osw_pkg::OFF_STAT, 32'h0);
        chk(q, 32'h40000181);
    endtask : t_wchk

    task automatic t_search();
        bus(1'b1, osw_pkg::OFF_CFG, 32'h00030A21);
        bus(1'b1, osw_pkg::OFF_CTRL, 32'h00000003);
        wst(osw_pkg::ST_HIGH);
        chk({31'h0, dir_neg_o}, 32'h1);
        sense <= 4'h8;
        wst(osw_pkg::ST_LOW);
        sense <= 4'h9;
        wst(osw_pkg::ST_IDLE);
        chk({31'h0, q[28]}, 32'h1);
        bus(1'b1, osw_pkg::OFF_CTRL, 32'h00000006);
        wst(osw_pkg::ST_IDLE);
        bus(1'b1, osw_pkg::OFF_CFG, 32'h00030A33);
        sense <= 4'h8;
        bus(1'b1, osw_pkg::OFF_CTRL, 32'h00000003);
        wst(osw_pkg::ST_HIGH);
        chk({31'h0, dir_neg_o}, 32'h0);
        sense <= 4'h0;
        wst(osw_pkg::ST_LOW);
        bus(1'b1, osw_pkg::OFF_CTRL, 32'h00000006);
        wst(osw_pkg::ST_IDLE);
    endtask : t_search

    task automatic t_abs();
        chk(abs_corr_pos_o, 32'h00000100);
        bus(1'b1, osw_pkg::OFF_CORR, 32'h00000010);
        bus(1'b1, osw_pkg::OFF_CFG, 32'h00030AA0);
        @(posedge clock_i);
        chk(abs_corr_pos_o, 32'h00000110);
    endtask : t_abs

    // ====
    // Sequence and hang guard
    // The ceiling allows the short wiring check plus register traffic.
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        t_reset();
        t_sat();
        t_wchk();
        t_search();
        t_abs();
        end_of_test();
    end
endmodule : tb_osw_axis
